// >>> device_option_word_decoder.sv
/*
 * Device option word: storage written by the external programmer,
 * decode into control outputs latched at reset, start-up hold timers,
 * watchdog fed by its own oscillator, sleep and wake, self-write guard.
 * Assumes pins arrive asynchronously; core strobes are on core_clk.
 */
//
// Contract
// [RULE_01] programmed option bit reads 0, erased 1
// [RULE_02] erased word reads all fourteen ones
// [RULE_03] word at 2007h, reachable only programming
// [RULE_04] top bit 0 protects all program memory
// [RULE_05] unimplemented option bits always read one
// [RULE_06] debug bit 0 gives debugger two pins
// [RULE_07] large variant guard blocks low ranges
// [RULE_08] small variant guard blocks smaller ranges
// [RULE_09] eeprom bit 0 protects data eeprom
// [RULE_10] low-voltage bit selects programming entry pin
// [RULE_11] brown-out reset enabled when bit one
// [RULE_12] power-up timer enable bit active low
// [RULE_13] power-up timer holds reset 72 ms
// [RULE_14] watchdog bit on, software cannot disable
// [RULE_15] watchdog clocked by own oscillator
// [RULE_16] two bits select oscillator mode
// [RULE_17] start-up timer holds until crystal stable
// [RULE_18] sleep ends on reset, watchdog, interrupt
// [RULE_19] sample at reset, hold outputs while running
module device_option_word_decoder
    import option_word_pkg::*;
#(
    parameter int  POWERUP_DELAY_TIMER_COUNT = POWERUP_DELAY_TIMER_CYCLES,
    parameter int  OST_COUNT  = OST_CYCLES,
    parameter int  WDT_COUNT  = WDT_TICKS,
    parameter bit  LARGE_MEM  = 1'b1
) (
    // clock and power-on reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // pins
    input  wire logic                          masterClearPin_n,
    input  wire logic                          masterClearHighVolt,
    input  wire logic                          lowVoltProgInput,
    input  wire logic                          brownoutDetect,
    input  wire logic                          watchdogOscClk,
    // programming port
    input  wire logic [option_word_pkg::ADDR_W-1:0] progAddr,
    input  wire logic [option_word_pkg::WORD_W-1:0] progWrData,
    input  wire logic                          progWrite,
    input  wire logic                          progRead,
    input  wire logic                          progErase,
    output logic [option_word_pkg::WORD_W-1:0] progRdData,
    output logic                               progAck,
    output logic                               progModeActive,
    // core side
    input  wire logic                          sleepReq,
    input  wire logic                          watchdogClear,
    input  wire logic                          irqPending,
    input  wire logic [option_word_pkg::PMEM_AW-1:0] selfWrAddr,
    output logic                               selfWrAllowed,
    // decoded controls and reset status
    output option_word_pkg::option_ctrl_type   ctrl,
    output logic                               debuggerPinsOwned,
    output logic                               progEntryPinOwned,
    output logic                               coreReset,
    output logic                               sleeping,
    output logic                               wakePulse,
    output logic                               watchdogResetFlag
);
    import option_word_pkg::*;

    typedef enum {
        ST_HOLD,
        ST_SAMPLE,
        ST_POWERUP_DELAY_TIMER,
        ST_OST,
        ST_RUN,
        ST_SLEEP
    } state_type;

    // last blocked address for a guard value on this variant
    function automatic logic [12:0] guardLimit(input logic [1:0] g);
        logic [12:0] lim;
        lim = '0;
        case (g)
            2'b10:   lim = LARGE_MEM ? BIG_LIM_10 : SML_LIM_10; // [RULE_07] [RULE_08]
            2'b01:   lim = LARGE_MEM ? BIG_LIM_01 : SML_LIM_01; // [RULE_07] [RULE_08]
            2'b00:   lim = LARGE_MEM ? BIG_LIM_00 : SML_LIM_00; // [RULE_07] [RULE_08]
            default: lim = '0;
        endcase
        return lim;
    endfunction : guardLimit

    function automatic option_ctrl_type decodeWord(input logic [13:0] w);
        option_ctrl_type c;
        c.flashProtect    = ~w[FLASH_PROT_BIT];                 // [RULE_04]
        c.eepromProtect   = ~w[EEPROM_BIT];                     // [RULE_09]
        c.debugEn         = ~w[DEBUG_BIT];                      // [RULE_06]
        c.lowVoltProgEn   = w[LVP_BIT];                         // [RULE_10]
        c.brownoutResetEn = w[BOR_BIT];                         // [RULE_11]
        c.powerupDelayEn  = ~w[POWERUP_DELAY_TIMER_BIT];                       // [RULE_12]
        c.watchdogRunEn   = w[WDT_BIT];                         // [RULE_14]
        c.selfWriteGuard  = w[GUARD_LSB +: 2];
        c.oscModeSelect   = osc_mode_type'(w[OSC_LSB +: 2]);    // [RULE_16]
        return c;
    endfunction : decodeWord

    // pin synchronisers; stage 2 is the first readable copy
    pin_sync_type syncA;
    pin_sync_type syncB;
    logic         wdtOscPrev;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA      <= '{mclrN: 1'b0, default: 1'b0};
            syncB      <= '{mclrN: 1'b0, default: 1'b0};
            wdtOscPrev <= 1'b0;
        end else begin
            syncA      <= '{masterClearPin_n, masterClearHighVolt, lowVoltProgInput,
                            brownoutDetect, watchdogOscClk};
            syncB      <= syncA;
            wdtOscPrev <= syncB.wdtOsc;
        end
    end

    // state
    logic [13:0]     optionWord;
    option_ctrl_type ctrlLive;
    state_type       state;
    logic [31:0]     timer;
    logic [31:0]     wdtCount;
    logic            powerOn;

    logic [13:0]     next_optionWord;
    option_ctrl_type next_ctrl;
    state_type       next_state;
    logic [31:0]     next_timer;
    logic [31:0]     next_wdtCount;
    logic            next_powerOn;
    logic [13:0]     next_progRdData;
    logic            next_progAck;
    logic            next_progModeActive;
    logic            next_selfWrAllowed;
    logic            next_coreReset;
    logic            next_sleeping;
    logic            next_wakePulse;
    logic            next_watchdogResetFlag;

    logic            progEntry;
    logic            wdtTick;
    logic            wdtExpire;
    logic            resetCause;
    logic            isCrystal;
    logic [12:0]     lim;

    always_comb begin
        ctrlLive   = decodeWord(optionWord);
        // entry by high voltage, or by the pin when low-voltage is enabled
        progEntry  = syncB.hvProg | (ctrlLive.lowVoltProgEn & syncB.lvProg); // [RULE_10]
        wdtTick    = syncB.wdtOsc & ~wdtOscPrev;                             // [RULE_15]
        wdtExpire  = ctrl.watchdogRunEn && wdtTick
                     && (wdtCount == 32'(WDT_COUNT - 1));
        resetCause = ~syncB.mclrN | progEntry
                     | (ctrl.brownoutResetEn & syncB.brownout);              // [RULE_11]
        isCrystal  = ctrl.oscModeSelect != RESISTOR_CAP_OSC;
        lim        = guardLimit(ctrl.selfWriteGuard);

        next_optionWord        = optionWord;
        next_ctrl              = ctrl;
        next_state             = state;
        next_timer             = timer;
        next_wdtCount          = wdtCount;
        next_powerOn           = powerOn;
        next_progRdData        = progRdData;
        next_progAck           = 1'b0;
        next_progModeActive    = progEntry;
        next_selfWrAllowed     = 1'b0;
        next_wakePulse         = 1'b0;
        next_watchdogResetFlag = watchdogResetFlag;

        // programming access, only in programming mode and at its address
        if (progModeActive && progAddr == OPTION_ADDR) begin                 // [RULE_03]
            if (progErase) begin
                next_optionWord = ERASED_WORD;                               // [RULE_02]
                next_progAck    = 1'b1;
            end else if (progWrite) begin
                // a 0 programs a bit; unimplemented bits stay 1
                next_optionWord = (optionWord & progWrData) | UNIMP_MASK;    // [RULE_01] [RULE_05]
                next_progAck    = 1'b1;
            end else if (progRead) begin
                next_progRdData = optionWord | UNIMP_MASK;                   // [RULE_05]
                next_progAck    = 1'b1;
            end
        end else if (progModeActive && (progRead || progWrite || progErase)) begin
            next_progRdData = '0;
            next_progAck    = 1'b1;
        end

        // self-write check against the latched guard
        if (ctrl.selfWriteGuard == 2'b11) begin
            next_selfWrAllowed = selfWrAddr <= (LARGE_MEM ? BIG_TOP : SML_TOP); // [RULE_07]
        end else begin
            next_selfWrAllowed = (selfWrAddr > lim)
                && (selfWrAddr <= (LARGE_MEM ? BIG_TOP : SML_TOP));           // [RULE_07] [RULE_08]
        end

        // watchdog: held at zero in ST_HOLD and ST_SAMPLE, while the latched option bit is off, and while watchdogClear is high
        if (!ctrl.watchdogRunEn || state == ST_HOLD || state == ST_SAMPLE
            || watchdogClear) begin                                           // [RULE_14]
            next_wdtCount = '0;
        end else if (wdtTick) begin
            next_wdtCount = wdtExpire ? '0 : wdtCount + 32'd1;
        end

        case (state)
            ST_HOLD: begin
                if (!resetCause) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                next_ctrl  = ctrlLive;                                        // [RULE_19]
                next_timer = '0;
                if (powerOn && ctrlLive.powerupDelayEn) begin
                    next_state = ST_POWERUP_DELAY_TIMER;                                     // [RULE_13]
                end else if (powerOn && ctrlLive.oscModeSelect != RESISTOR_CAP_OSC) begin
                    next_state = ST_OST;
                end else begin
                    next_state = ST_RUN;
                end
            end
            ST_POWERUP_DELAY_TIMER: begin
                next_timer = timer + 32'd1;
                if (timer == 32'(POWERUP_DELAY_TIMER_COUNT - 1)) begin                       // [RULE_13]
                    next_timer = '0;
                    next_state = isCrystal ? ST_OST : ST_RUN;
                end
            end
            ST_OST: begin
                next_timer = timer + 32'd1;
                if (timer == 32'(OST_COUNT - 1)) begin                        // [RULE_17]
                    next_timer = '0;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_powerOn = 1'b0;
                if (sleepReq) begin
                    next_state = ST_SLEEP;
                end
                if (wdtExpire) begin
                    next_watchdogResetFlag = 1'b1;
                    next_state             = ST_HOLD;
                end
            end
            ST_SLEEP: begin
                if (wdtExpire || irqPending) begin                            // [RULE_18]
                    next_wakePulse = 1'b1;
                    next_state     = ST_RUN;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase

        // external reset, brown-out or programming entry wins
        if (resetCause) begin                                                 // [RULE_18]
            next_state = ST_HOLD;
            next_timer = '0;
            if (!syncB.mclrN) begin
                next_watchdogResetFlag = 1'b0;
            end
        end

        next_coreReset = next_state != ST_RUN && next_state != ST_SLEEP;     // [RULE_13] [RULE_17]
        next_sleeping  = next_state == ST_SLEEP;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            optionWord        <= ERASED_WORD;                                 // [RULE_02]
            ctrl              <= decodeWord(ERASED_WORD);
            state             <= ST_HOLD;
            timer             <= '0;
            wdtCount          <= '0;
            powerOn           <= 1'b1;
            progRdData        <= '0;
            progAck           <= 1'b0;
            progModeActive    <= 1'b0;
            selfWrAllowed     <= 1'b0;
            coreReset         <= 1'b1;
            sleeping          <= 1'b0;
            wakePulse         <= 1'b0;
            watchdogResetFlag <= 1'b0;
            debuggerPinsOwned <= 1'b0;
            progEntryPinOwned <= 1'b1;
        end else begin
            optionWord        <= next_optionWord;
            ctrl              <= next_ctrl;
            state             <= next_state;
            timer             <= next_timer;
            wdtCount          <= next_wdtCount;
            powerOn           <= next_powerOn;
            progRdData        <= next_progRdData;
            progAck           <= next_progAck;
            progModeActive    <= next_progModeActive;
            selfWrAllowed     <= next_selfWrAllowed;
            coreReset         <= next_coreReset;
            sleeping          <= next_sleeping;
            wakePulse         <= next_wakePulse;
            watchdogResetFlag <= next_watchdogResetFlag;
            debuggerPinsOwned <= next_ctrl.debugEn;                           // [RULE_06]
            progEntryPinOwned <= next_ctrl.lowVoltProgEn;                     // [RULE_10]
        end
    end

endmodule : device_option_word_decoder

// >>> option_word_pkg.sv
/*
 * Shared constants and types for the device option word decoder:
 * word layout, erased value, write guard limits and start-up timing.
 * Assumes a single 40 MHz core clock.
 */
package option_word_pkg;

    localparam int          WORD_W        = 14;
    localparam int          ADDR_W        = 14;
    localparam int          PMEM_AW       = 13;
    localparam logic [13:0] OPTION_ADDR   = 14'h2007;
    localparam logic [13:0] ERASED_WORD   = 14'h3FFF;
    // bit 12 and bits 5..4 are not implemented
    localparam logic [13:0] UNIMP_MASK    = 14'h1030;

    localparam int FLASH_PROT_BIT = 13;
    localparam int DEBUG_BIT      = 11;
    localparam int GUARD_LSB      = 9;
    localparam int EEPROM_BIT     = 8;
    localparam int LVP_BIT        = 7;
    localparam int BOR_BIT        = 6;
    localparam int POWERUP_DELAY_TIMER_BIT       = 3;
    localparam int WDT_BIT        = 2;
    localparam int OSC_LSB        = 0;

    // top of the blocked range per guard value and top of memory, larger variant
    localparam logic [12:0] BIG_LIM_10  = 13'h00FF;
    localparam logic [12:0] BIG_LIM_01  = 13'h07FF;
    localparam logic [12:0] BIG_LIM_00  = 13'h0FFF;
    localparam logic [12:0] BIG_TOP     = 13'h1FFF;
    // smaller variant
    localparam logic [12:0] SML_LIM_10  = 13'h00FF;
    localparam logic [12:0] SML_LIM_01  = 13'h03FF;
    localparam logic [12:0] SML_LIM_00  = 13'h07FF;
    localparam logic [12:0] SML_TOP     = 13'h0FFF;

    localparam int CLK_HZ        = 40_000_000;
    localparam int POWERUP_DELAY_TIMER_MS       = 72;
    localparam int POWERUP_DELAY_TIMER_CYCLES   = POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000);
    localparam int OST_CYCLES    = 1024;
    localparam int WDT_TICKS     = 2048;

    typedef enum logic [1:0] {
        LOW_POWER_CRYSTAL  = 2'b00,
        STANDARD_CRYSTAL   = 2'b01,
        HIGH_SPEED_CRYSTAL = 2'b10,
        RESISTOR_CAP_OSC   = 2'b11
    } osc_mode_type;

    typedef struct packed {
        logic         flashProtect;
        logic         eepromProtect;
        logic         debugEn;
        logic         lowVoltProgEn;
        logic         brownoutResetEn;
        logic         powerupDelayEn;
        logic         watchdogRunEn;
        logic [1:0]   selfWriteGuard;
        osc_mode_type oscModeSelect;
    } option_ctrl_type;

    typedef struct packed {
        logic         mclrN;
        logic         hvProg;
        logic         lvProg;
        logic         brownout;
        logic         wdtOsc;
    } pin_sync_type;

endpackage : option_word_pkg

// >>> device_option_word_decoder_props.sv
/* Port checker for the option word decoder.
   Assumes it is bound onto the decoder top module. */
module device_option_word_decoder_props
    import option_word_pkg::*;
#(
    parameter bit LARGE_MEM = 1'b1
) (
    // clock and reset
    input wire logic                                   core_clk,
    input wire logic                                   rst_n,
    // programming port
    input wire logic [option_word_pkg::ADDR_W-1:0]     progAddr,
    input wire logic                                   progWrite,
    input wire logic                                   progRead,
    input wire logic                                   progErase,
    input wire logic [option_word_pkg::WORD_W-1:0]     progRdData,
    input wire logic                                   progAck,
    input wire logic                                   progModeActive,
    // core side
    input wire logic                                   sleepReq,
    input wire logic [option_word_pkg::PMEM_AW-1:0]    selfWrAddr,
    input wire logic                                   selfWrAllowed,
    input wire option_word_pkg::option_ctrl_type       ctrl,
    input wire logic                                   coreReset,
    input wire logic                                   sleeping,
    input wire logic                                   wakePulse,
    input wire logic                                   watchdogResetFlag
);
    logic [12:0] guardLim;
    logic        next_expAllowed;
    logic        expAllowed;
    wire         rdReq = progModeActive && progRead && !progWrite && !progErase;

    always_comb begin
        case (ctrl.selfWriteGuard)
            2'b10:   guardLim = LARGE_MEM ? BIG_LIM_10 : SML_LIM_10;
            2'b01:   guardLim = LARGE_MEM ? BIG_LIM_01 : SML_LIM_01;
            default: guardLim = LARGE_MEM ? BIG_LIM_00 : SML_LIM_00;
        endcase
        next_expAllowed = (ctrl.selfWriteGuard == 2'b11 || selfWrAddr > guardLim)
                          && selfWrAddr <= (LARGE_MEM ? BIG_TOP : SML_TOP);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            expAllowed <= 1'b0;
        end else begin
            expAllowed <= next_expAllowed;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    strobe_acked_a: assert property (progModeActive && (progWrite || progRead || progErase) |=> progAck)
        else $error("strobe not acknowledged");
    ack_cause_a: assert property (progAck |-> $past(progModeActive && (progWrite || progRead || progErase)))
        else $error("acknowledge without accepted strobe");
    unimp_ones_a: assert property (rdReq && progAddr == OPTION_ADDR |=> (progRdData & UNIMP_MASK) == UNIMP_MASK)
        else $error("unimplemented option bits read zero");
    other_addr_a: assert property (rdReq && progAddr != OPTION_ADDR |=> progRdData == '0)
        else $error("read away from option word not zero");
    write_guard_a: assert property (selfWrAllowed == expAllowed)
        else $error("self write permission wrong for guard");
    ctrl_hold_a: assert property (!coreReset && !$past(coreReset) |-> $stable(ctrl))
        else $error("controls changed while running");
    sleep_entry_a: assert property ($rose(sleeping) |-> $past(sleepReq) && !$past(coreReset))
        else $error("sleep entered without request");
    wake_pulse_a: assert property (wakePulse |-> $fell(sleeping) ##1 !wakePulse)
        else $error("wake pulse malformed");
    watchdog_reset_a: assert property ($rose(watchdogResetFlag) |-> ctrl.watchdogRunEn ##[0:2] coreReset)
        else $error("watchdog reset wrong");

    cover property (wakePulse);
    cover property ($rose(watchdogResetFlag));
    cover property (!coreReset && !selfWrAllowed);
endmodule : device_option_word_decoder_props

bind device_option_word_decoder device_option_word_decoder_props #(.LARGE_MEM(LARGE_MEM)) u_props (
    .core_clk(core_clk), .rst_n(rst_n), .progAddr(progAddr), .progWrite(progWrite),
    .progRead(progRead), .progErase(progErase), .progRdData(progRdData), .progAck(progAck),
    .progModeActive(progModeActive), .sleepReq(sleepReq), .selfWrAddr(selfWrAddr),
    .selfWrAllowed(selfWrAllowed), .ctrl(ctrl), .coreReset(coreReset), .sleeping(sleeping),
    .wakePulse(wakePulse), .watchdogResetFlag(watchdogResetFlag)
);

// >>> option_programmer_model.sv
/* Programmer model: enters programming mode and runs word accesses.
   Assumes the decoder programming port on the same clock. */
module option_programmer_model
    import option_word_pkg::*;
(
    // clock
    input wire logic                               core_clk,
    // entry pins
    output logic                                   masterClearHighVolt,
    output logic                                   lowVoltProgInput,
    // programming port
    output logic [option_word_pkg::ADDR_W-1:0]     progAddr,
    output logic [option_word_pkg::WORD_W-1:0]     progWrData,
    output logic                                   progWrite,
    output logic                                   progRead,
    output logic                                   progErase,
    input wire logic                               progAck,
    input wire logic                               progModeActive
);
    logic [WORD_W-1:0] expQ[$];
    logic [WORD_W-1:0] lastRead = '0;

    initial begin
        {masterClearHighVolt, lowVoltProgInput, progWrite, progRead, progErase} = '0;
        progAddr = '0;
        progWrData = '0;
    end

    // word is reachable only in programming mode
    task automatic enter(input logic viaLowVolt, input logic on);
        int n;
        n = 0;
        @(posedge core_clk);
        if (viaLowVolt) lowVoltProgInput <= on;
        else masterClearHighVolt <= on;
        while (progModeActive !== on && n < 20) begin
            @(negedge core_clk);
            n++;
        end
    endtask : enter

    // kind 0 read, 1 write, 2 erase; the bench monitor pops the note
    task automatic access(input int kind, input logic [ADDR_W-1:0] addr,
                          input logic [WORD_W-1:0] data, input logic [WORD_W-1:0] expRd);
        if (kind == 0) lastRead = expRd;
        expQ.push_back(lastRead);
        @(posedge core_clk);
        progAddr <= addr;
        progWrData <= data;
        progRead <= (kind == 0);
        progWrite <= (kind == 1);
        progErase <= (kind == 2);
        @(posedge core_clk);
        {progRead, progWrite, progErase} <= 3'b000;
        @(posedge core_clk);
        // released lines show the inverse, not the old value
        progAddr <= ~addr;
        progWrData <= ~data;
    endtask : access
endmodule : option_programmer_model

// >>> device_option_word_decoder_test.sv
/* Self-checking bench for the option word decoder.
   Assumes the programmer model and the bound port checker. */
`define check(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp); end end
module device_option_word_decoder_test
    import option_word_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic masterClearPin_n = 1'b1;
    logic watchdogOscClk = 1'b0;
    logic sleepReq = 1'b0;
    logic irqPending = 1'b0;
    logic brownoutDetect = 1'b0;
    logic watchdogClear = 1'b0;
    logic [PMEM_AW-1:0] selfWrAddr = '0;
    logic masterClearHighVolt, lowVoltProgInput, progWrite, progRead, progErase, progAck;
    logic progModeActive, selfWrAllowed, debuggerPinsOwned, progEntryPinOwned, coreReset;
    logic sleeping, wakePulse, watchdogResetFlag;
    logic [ADDR_W-1:0] progAddr;
    logic [WORD_W-1:0] progWrData, progRdData, expRd;
    option_ctrl_type ctrl;
    int checked = 0;
    int miscompares = 0;

    always #12.5 core_clk = ~core_clk;

    device_option_word_decoder #(.POWERUP_DELAY_TIMER_COUNT(20), .OST_COUNT(8), .WDT_COUNT(4), .LARGE_MEM(1'b1))
    u_device_option_word_decoder (.*);
    option_programmer_model u_prog (.*);

    function automatic option_ctrl_type dec(input logic [13:0] w);
        dec = '{!w[13], !w[8], !w[11], w[7], w[6], !w[3], w[2], w[10:9], osc_mode_type'(w[1:0])};
    endfunction : dec

    function automatic logic allowed(input logic [1:0] g, input logic [12:0] a);
        logic [12:0] lim;
        lim = (g == 2'b10) ? 13'h00FF : (g == 2'b01) ? 13'h07FF : 13'h0FFF;
        allowed = (g == 2'b11 || a > lim) && a <= 13'h1FFF;
    endfunction : allowed

    task automatic waitFor(ref logic sig, input logic val);
        int n;
        n = 0;
        while (sig !== val && n < 400) begin
            @(negedge core_clk);
            n++;
        end
    endtask : waitFor

    task automatic selfWr(input logic [12:0] a, input logic [1:0] g);
        @(posedge core_clk);
        selfWrAddr <= a;
        @(posedge core_clk);
        #1;
        `check(selfWrAllowed, allowed(g, a))
    endtask : selfWr

    task automatic pinReset();
        @(posedge core_clk);
        masterClearPin_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        masterClearPin_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        waitFor(coreReset, 1'b0);
        `check(coreReset, 1'b0)
    endtask : pinReset

    task automatic ticks(input int n);
        repeat (n) begin
            #170 watchdogOscClk = 1'b1;
            #170 watchdogOscClk = 1'b0;
        end
    endtask : ticks

    task automatic goSleep();
        @(posedge core_clk);
        sleepReq <= 1'b1;
        @(posedge core_clk);
        sleepReq <= 1'b0;
        @(negedge core_clk);
        `check(sleeping, 1'b1)
    endtask : goSleep

    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    always @(posedge core_clk) begin
        if (progAck === 1'b1) begin
            if (u_prog.expQ.size() == 0) begin
                `check(progAck, 1'b0)
            end else begin
                expRd = u_prog.expQ.pop_front();
                `check(progRdData, expRd)
            end
        end
    end

    initial begin
        #200_000;
        miscompares++;
        summarize();
    end

    initial begin
        logic [13:0] words [4] = '{14'h15B2, 14'h3A7D, 14'h39F4, 14'h3FFF};
        logic [12:0] edges [6] = '{13'h00FF, 13'h0100, 13'h07FF, 13'h0800, 13'h0FFF, 13'h1000};
        int seed;
        seed = 32'h2d2d_18f0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        waitFor(coreReset, 1'b0);
        `check(ctrl, dec(ERASED_WORD))
        u_prog.enter(1'b1, 1'b1);
        u_prog.access(0, OPTION_ADDR, '0, ERASED_WORD);
        u_prog.access(0, 14'h2006, '0, 14'h0000);
        u_prog.enter(1'b1, 1'b0);
        $display("test erased word done");
        foreach (words[i]) begin
            u_prog.enter(1'b0, 1'b1);
            u_prog.access(2, OPTION_ADDR, '0, '0);
            u_prog.access(1, OPTION_ADDR, words[i] ^ (14'($random(seed)) & UNIMP_MASK), '0);
            u_prog.access(0, OPTION_ADDR, '0, words[i]);
            u_prog.enter(1'b0, 1'b0);
            pinReset();
            `check(ctrl, dec(words[i]))
            `check(debuggerPinsOwned, ~words[i][11])
            `check(progEntryPinOwned, words[i][7])
            foreach (edges[k]) selfWr(edges[k], words[i][10:9]);
            selfWr(13'($random(seed)), words[i][10:9]);
            if (!words[i][2]) ticks(6);
            `check(watchdogResetFlag, 1'b0)
            $display("test word %0d done", i);
        end
        goSleep();
        @(posedge core_clk);
        irqPending <= 1'b1;
        waitFor(wakePulse, 1'b1);
        `check({wakePulse, sleeping}, 2'b10)
        irqPending <= 1'b0;
        goSleep();
        fork
            ticks(6);
            waitFor(wakePulse, 1'b1);
        join_any
        `check({wakePulse, sleeping, watchdogResetFlag}, 3'b100)
        wait fork;
        ticks(5);
        `check(watchdogResetFlag, 1'b1)
        pinReset();
        `check(watchdogResetFlag, 1'b0)
        $display("test sleep and watchdog done");
        `check(u_prog.expQ.size(), 0)
        summarize();
    end
endmodule : device_option_word_decoder_test
